// ### include/acs_pkg.sv
// package: constants and types for the converter calibration sequencer
package acs_pkg;
   // apb register byte offsets
   localparam logic [7:0]  REG_CTRL      = 8'h00;  // mode field and start
   localparam logic [7:0]  REG_STATUS    = 8'h04;  // sequencer state, ready flag
   localparam logic [7:0]  REG_DATA      = 8'h08;  // data output register
   localparam logic [7:0]  REG_OFFSET    = 8'h0C;  // offset coefficient
   localparam logic [7:0]  REG_POSFS     = 8'h10;  // positive full-scale coefficient
   localparam logic [7:0]  REG_NEGFS     = 8'h14;  // negative full-scale coefficient
   localparam logic [7:0]  REG_PERIOD    = 8'h18;  // conversion period in clocks
   // field positions
   localparam int          CTRL_MODE_LSB = 0;      // op_mode_select in bits 2:0
   localparam int          CTRL_GAIN_LSB = 4;      // input_gain_amp code in bits 6:4
   // reset values
   localparam logic [23:0] OFFSET_RST    = 24'h000000;
   localparam logic [23:0] POSFS_RST     = 24'h800000;
   localparam logic [23:0] NEGFS_RST     = 24'h800000;
   localparam logic [15:0] PERIOD_RST    = 16'h0064;  // clocks per conversion period
   // step lengths in conversion periods
   localparam logic [2:0]  SETTLE_CNV    = 3'h3;   // conversion and the steps of multi-step modes, except the system gain tail
   localparam logic [2:0]  SETTLE_SYS    = 3'h4;   // single system calibrations
   localparam logic [2:0]  SETTLE_ONE    = 3'h1;   // tail of system gain
   // mode codes
   localparam logic [2:0]  MD_CONV       = 3'h0;
   localparam logic [2:0]  MD_SELF       = 3'h1;
   localparam logic [2:0]  MD_SYS_OFF    = 3'h2;
   localparam logic [2:0]  MD_SYS_POS    = 3'h3;
   localparam logic [2:0]  MD_SYS_NEG    = 3'h4;
   localparam logic [2:0]  MD_OFF_IGAIN  = 3'h5;
   localparam logic [2:0]  MD_SYS_GAIN   = 3'h6;
   // analog input routing
   typedef enum logic [1:0] {
      ACS_IN_EXT, ACS_IN_SHORT, ACS_IN_REF_POS, ACS_IN_REF_NEG
   } acs_route_t;
   // sequencer states
   typedef enum logic [3:0] {
      ACS_IDLE, ACS_CONV, ACS_OFF, ACS_POS, ACS_NEG, ACS_TAIL,
      ACS_GAIN_NEG, ACS_GAIN_POS, ACS_DONE
   } acs_state_t;
endpackage

// ### hdl/acs_period_div.sv
// conversion period divider: one-cycle tick every period_len clocks
`timescale 1ns/1ps
module acs_period_div (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        restart,    // realign to a new step
   input  wire logic [15:0] period_len, // clocks per conversion period
   output logic             tick        // one-cycle pulse at period end
);
   logic [15:0] cnt_ff;  // clocks elapsed in current period

   // count up, pulse at the end; a zero length behaves as one clock
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_ff <= 16'h0000;
         tick   <= 1'b0;
      end else if (restart) begin
         cnt_ff <= 16'h0000;
         tick   <= 1'b0;
      end else if (cnt_ff + 16'h0001 >= period_len) begin
         cnt_ff <= 16'h0000;
         tick   <= 1'b1;
      end else begin
         cnt_ff <= cnt_ff + 16'h0001;
         tick   <= 1'b0;
      end
   end
endmodule

// ### hdl/acs_sequencer.sv
// calibration sequencer for the sigma-delta converter, with apb registers
// Overview of operation
// - conversion: ready low after three periods
// - conversion never writes coefficients; corrects results
// - self offset: short inputs, three periods, write
// - then reference across modulator, write positive
// - reverse reference, three periods, write negative
// - three more periods, then ready low
// - system offset: store input, ready after four
// - system positive: store input, ready after four
// - system negative: store input, ready after four
// - offset/internal gain: offset, positive, negative, tail
// - system gain: negative, reverse, then positive
// - one more period, then ready low
// - mode field codes select the operation
// - ready returns high after data read
`timescale 1ns/1ps
module acs_sequencer (
   input  wire logic        CLK,
   input  wire logic        NRST,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic [31:0]      PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   input  wire logic        SAMPLE_VALID,       // filter word ready, one pulse
   input  wire logic [23:0] SAMPLE_DATA,        // raw filter word
   output logic [1:0]       INPUT_ROUTE,        // analog switch setting
   output logic             RESULT_VALID_N      // data-ready, active low
);
   logic [2:0]  op_mode_select_ff;  // mode field
   logic [2:0]  gain_ff;            // input_gain_amp code, stored only
   logic [15:0] period_ff;          // clocks per conversion period
   logic [23:0] offset_ff;          // offset coefficient
   logic [23:0] posfs_ff;           // positive full-scale coefficient
   logic [23:0] negfs_ff;           // negative full-scale coefficient
   logic [23:0] data_ff;            // data output register
   logic [23:0] raw_ff;             // latest raw filter word
   logic [2:0]  pcnt_ff;            // periods elapsed in the step
   logic        start_ff;           // pulse: mode field written
   acs_pkg::acs_state_t state_ff;   // sequencer state
   acs_pkg::acs_route_t route_ff;   // switch setting before the output register
   logic        tick;               // end of a conversion period
   logic        step_done;          // step has run its length
   logic [2:0]  step_len;           // periods for current step
   logic        apb_wr, apb_rd;
   logic        data_read;          // complete read of the data register

   // a transfer completes in its first access cycle; no wait states
   assign apb_wr    = PSEL && PENABLE && PWRITE;
   assign apb_rd    = PSEL && PENABLE && !PWRITE;
   assign data_read = apb_rd && (PADDR == acs_pkg::REG_DATA);

   // decode used by the error answer only; the read mux has its own case
   function automatic logic addr_known(input logic [7:0] a);
      addr_known = (a == acs_pkg::REG_CTRL)   || (a == acs_pkg::REG_STATUS) ||
                   (a == acs_pkg::REG_DATA)   || (a == acs_pkg::REG_OFFSET) ||
                   (a == acs_pkg::REG_POSFS)  || (a == acs_pkg::REG_NEGFS)  ||
                   (a == acs_pkg::REG_PERIOD);
   endfunction

   // divider realigns only at a mode start; step ends fall on a tick, so a restart
   // there would stretch every later step by one clock
   acs_period_div u_div (
      .clk        (CLK),
      .nrst       (NRST),
      .restart    (start_ff),
      .period_len (period_ff),
      .tick       (tick)
   );

   // step length per state
   always_comb begin
      case (state_ff)
         acs_pkg::ACS_CONV: begin
            step_len = acs_pkg::SETTLE_CNV;
         end
         acs_pkg::ACS_OFF: begin
            step_len = (op_mode_select_ff == acs_pkg::MD_SELF ||
                        op_mode_select_ff == acs_pkg::MD_OFF_IGAIN) ?
                       acs_pkg::SETTLE_CNV : acs_pkg::SETTLE_SYS;
         end
         acs_pkg::ACS_POS, acs_pkg::ACS_NEG: begin
            step_len = (op_mode_select_ff == acs_pkg::MD_SYS_POS ||
                        op_mode_select_ff == acs_pkg::MD_SYS_NEG) ?
                       acs_pkg::SETTLE_SYS : acs_pkg::SETTLE_CNV;
         end
         acs_pkg::ACS_GAIN_NEG, acs_pkg::ACS_GAIN_POS: begin
            step_len = acs_pkg::SETTLE_CNV;
         end
         acs_pkg::ACS_TAIL: begin
            step_len = (op_mode_select_ff == acs_pkg::MD_SYS_GAIN) ?
                       acs_pkg::SETTLE_ONE : acs_pkg::SETTLE_CNV;
         end
         default: begin
            step_len = 3'h7;
         end
      endcase
   end

   assign step_done = tick && (pcnt_ff + 3'h1 >= step_len) &&
                      (state_ff != acs_pkg::ACS_IDLE) && (state_ff != acs_pkg::ACS_DONE);

   // period counter within a step
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         pcnt_ff <= 3'h0;
      end else if (start_ff || step_done) begin
         pcnt_ff <= 3'h0;
      end else if (tick && pcnt_ff != 3'h7) begin
         pcnt_ff <= pcnt_ff + 3'h1;
      end
   end

   // control registers written over apb; a mode write launches the sequence
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         op_mode_select_ff <= acs_pkg::MD_CONV;
         gain_ff           <= 3'h0;
         period_ff         <= acs_pkg::PERIOD_RST;
         start_ff          <= 1'b0;
      end else begin
         start_ff <= 1'b0;
         if (apb_wr && PADDR == acs_pkg::REG_CTRL) begin
            op_mode_select_ff <= PWDATA[acs_pkg::CTRL_MODE_LSB +: 3];
            gain_ff           <= PWDATA[acs_pkg::CTRL_GAIN_LSB +: 3];
            start_ff          <= 1'b1;
         end
         if (apb_wr && PADDR == acs_pkg::REG_PERIOD) begin
            period_ff <= PWDATA[15:0];
         end
      end
   end

   // sequencer: one state per measurement step
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         state_ff <= acs_pkg::ACS_IDLE;
         route_ff <= acs_pkg::ACS_IN_EXT;
      end else if (start_ff) begin
         // reserved code is not trapped; it simply parks the sequencer
         case (op_mode_select_ff)
            acs_pkg::MD_CONV: begin
               state_ff <= acs_pkg::ACS_CONV;
               route_ff <= acs_pkg::ACS_IN_EXT;
            end
            acs_pkg::MD_SELF: begin
               state_ff <= acs_pkg::ACS_OFF;
               route_ff <= acs_pkg::ACS_IN_SHORT;
            end
            acs_pkg::MD_SYS_OFF, acs_pkg::MD_OFF_IGAIN: begin
               state_ff <= acs_pkg::ACS_OFF;
               route_ff <= acs_pkg::ACS_IN_EXT;
            end
            acs_pkg::MD_SYS_POS: begin
               state_ff <= acs_pkg::ACS_POS;
               route_ff <= acs_pkg::ACS_IN_EXT;
            end
            acs_pkg::MD_SYS_NEG: begin
               state_ff <= acs_pkg::ACS_NEG;
               route_ff <= acs_pkg::ACS_IN_EXT;
            end
            acs_pkg::MD_SYS_GAIN: begin
               state_ff <= acs_pkg::ACS_GAIN_NEG;
               route_ff <= acs_pkg::ACS_IN_EXT;
            end
            default: begin
               state_ff <= acs_pkg::ACS_IDLE;
            end
         endcase
      end else if (step_done) begin
         case (state_ff)
            acs_pkg::ACS_CONV: begin
               state_ff <= acs_pkg::ACS_DONE;
            end
            acs_pkg::ACS_OFF: begin
               if (op_mode_select_ff == acs_pkg::MD_SYS_OFF) begin
                  state_ff <= acs_pkg::ACS_DONE;
               end else begin
                  state_ff <= acs_pkg::ACS_POS;
                  route_ff <= acs_pkg::ACS_IN_REF_POS;
               end
            end
            acs_pkg::ACS_POS: begin
               if (op_mode_select_ff == acs_pkg::MD_SYS_POS) begin
                  state_ff <= acs_pkg::ACS_DONE;
               end else begin
                  state_ff <= acs_pkg::ACS_NEG;
                  route_ff <= acs_pkg::ACS_IN_REF_NEG;
               end
            end
            acs_pkg::ACS_NEG: begin
               state_ff <= (op_mode_select_ff == acs_pkg::MD_SYS_NEG) ?
                           acs_pkg::ACS_DONE : acs_pkg::ACS_TAIL;
               route_ff <= acs_pkg::ACS_IN_EXT;
            end
            acs_pkg::ACS_GAIN_NEG: begin
               state_ff <= acs_pkg::ACS_GAIN_POS;
               route_ff <= acs_pkg::ACS_IN_REF_NEG;  // reference reversed internally
            end
            acs_pkg::ACS_GAIN_POS: begin
               state_ff <= acs_pkg::ACS_TAIL;
               route_ff <= acs_pkg::ACS_IN_EXT;
            end
            acs_pkg::ACS_TAIL: begin
               state_ff <= acs_pkg::ACS_DONE;
            end
            default: begin
               state_ff <= acs_pkg::ACS_IDLE;
            end
         endcase
      end else if (state_ff == acs_pkg::ACS_DONE && SAMPLE_VALID &&
                   op_mode_select_ff == acs_pkg::MD_CONV) begin
         state_ff <= acs_pkg::ACS_DONE;  // stay and keep converting
      end
   end

   // latest raw filter word
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         raw_ff <= 24'h000000;
      end else if (SAMPLE_VALID) begin
         raw_ff <= SAMPLE_DATA;
      end
   end

   // coefficient writes: hardware step end wins over a same-cycle apb write
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         offset_ff <= acs_pkg::OFFSET_RST;
         posfs_ff  <= acs_pkg::POSFS_RST;
         negfs_ff  <= acs_pkg::NEGFS_RST;
      end else begin
         if (step_done && state_ff == acs_pkg::ACS_OFF) begin
            offset_ff <= raw_ff;
         end else if (apb_wr && PADDR == acs_pkg::REG_OFFSET) begin
            offset_ff <= PWDATA[23:0];
         end
         if (step_done && (state_ff == acs_pkg::ACS_POS ||
                           state_ff == acs_pkg::ACS_GAIN_POS)) begin
            posfs_ff <= raw_ff;
         end else if (apb_wr && PADDR == acs_pkg::REG_POSFS) begin
            posfs_ff <= PWDATA[23:0];
         end
         if (step_done && (state_ff == acs_pkg::ACS_NEG ||
                           state_ff == acs_pkg::ACS_GAIN_NEG)) begin
            negfs_ff <= raw_ff;
         end else if (apb_wr && PADDR == acs_pkg::REG_NEGFS) begin
            negfs_ff <= PWDATA[23:0];
         end
      end
   end

   // output data: offset-corrected word, coefficients untouched here
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         data_ff <= 24'h000000;
      end else if (step_done || (state_ff == acs_pkg::ACS_DONE && SAMPLE_VALID &&
                                 op_mode_select_ff == acs_pkg::MD_CONV)) begin
         // gain slope scaling belongs to the filter arithmetic outside this block
         data_ff <= raw_ff - offset_ff;
      end
   end

   // data-ready: low when a result lands, high after it is read; set wins
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         RESULT_VALID_N <= 1'b1;
      end else if ((step_done && (state_ff == acs_pkg::ACS_CONV ||
                    (state_ff == acs_pkg::ACS_OFF && op_mode_select_ff == acs_pkg::MD_SYS_OFF) ||
                    (state_ff == acs_pkg::ACS_POS && op_mode_select_ff == acs_pkg::MD_SYS_POS) ||
                    (state_ff == acs_pkg::ACS_NEG && op_mode_select_ff == acs_pkg::MD_SYS_NEG) ||
                    state_ff == acs_pkg::ACS_TAIL)) ||
                   (state_ff == acs_pkg::ACS_DONE && SAMPLE_VALID &&
                    op_mode_select_ff == acs_pkg::MD_CONV)) begin
         RESULT_VALID_N <= 1'b0;
      end else if (start_ff || (PREADY && data_read)) begin
         RESULT_VALID_N <= 1'b1;
      end
   end

   // registered outputs
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         INPUT_ROUTE <= 2'h0;
      end else begin
         INPUT_ROUTE <= route_ff;
      end
   end

   // apb answer: pready in access cycle, error for unmapped offsets
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         PREADY  <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA  <= 32'h00000000;
      end else begin
         PREADY  <= PSEL && !PENABLE;
         PSLVERR <= PSEL && !PENABLE && !addr_known(PADDR);
         PRDATA  <= 32'h00000000;
         if (PSEL && !PENABLE && !PWRITE) begin
            case (PADDR)
               acs_pkg::REG_CTRL:   PRDATA <= {25'h0, gain_ff, 1'b0, op_mode_select_ff};
               acs_pkg::REG_STATUS: PRDATA <= {23'h0, RESULT_VALID_N, 4'h0, state_ff};
               acs_pkg::REG_DATA:   PRDATA <= {8'h00, data_ff};
               acs_pkg::REG_OFFSET: PRDATA <= {8'h00, offset_ff};
               acs_pkg::REG_POSFS:  PRDATA <= {8'h00, posfs_ff};
               acs_pkg::REG_NEGFS:  PRDATA <= {8'h00, negfs_ff};
               acs_pkg::REG_PERIOD: PRDATA <= {16'h0000, period_ff};
               default:             PRDATA <= 32'h00000000;
            endcase
         end
      end
   end

   // checks
   conv_no_coef_a: assert property (@(posedge CLK) disable iff (!NRST)
      (state_ff == acs_pkg::ACS_CONV || op_mode_select_ff == acs_pkg::MD_CONV) && !apb_wr
      |=> $stable(offset_ff) && $stable(posfs_ff) && $stable(negfs_ff))
      else $error("coefficient changed in conversion mode");
   self_short_a: assert property (@(posedge CLK) disable iff (!NRST)
      start_ff && op_mode_select_ff == acs_pkg::MD_SELF |=> route_ff == acs_pkg::ACS_IN_SHORT)
      else $error("self offset step not shorted");
   pos_ref_a: assert property (@(posedge CLK) disable iff (!NRST)
      step_done && state_ff == acs_pkg::ACS_OFF && op_mode_select_ff == acs_pkg::MD_SELF
      |=> state_ff == acs_pkg::ACS_POS && route_ff == acs_pkg::ACS_IN_REF_POS)
      else $error("reference not applied after offset step");
   neg_ref_a: assert property (@(posedge CLK) disable iff (!NRST)
      step_done && state_ff == acs_pkg::ACS_POS && op_mode_select_ff != acs_pkg::MD_SYS_POS
      |=> route_ff == acs_pkg::ACS_IN_REF_NEG && posfs_ff == $past(raw_ff))
      else $error("reference not reversed after positive step");
   tail_ready_a: assert property (@(posedge CLK) disable iff (!NRST)
      step_done && state_ff == acs_pkg::ACS_TAIL |=> !RESULT_VALID_N)
      else $error("ready missing after tail");
   sys_off_a: assert property (@(posedge CLK) disable iff (!NRST)
      step_done && state_ff == acs_pkg::ACS_OFF && op_mode_select_ff == acs_pkg::MD_SYS_OFF
      |=> offset_ff == $past(raw_ff) && !RESULT_VALID_N)
      else $error("system offset not stored");
   gain_order_a: assert property (@(posedge CLK) disable iff (!NRST)
      step_done && state_ff == acs_pkg::ACS_GAIN_NEG
      |=> state_ff == acs_pkg::ACS_GAIN_POS && negfs_ff == $past(raw_ff))
      else $error("system gain order wrong");
   read_clear_a: assert property (@(posedge CLK) disable iff (!NRST)
      PREADY && data_read && !step_done && !SAMPLE_VALID |=> RESULT_VALID_N)
      else $error("ready not released after data read");
endmodule

// ### sim/acs_filter_model.sv
// filter front-end model: one sample word per conversion period, chosen by the switch setting
`timescale 1ns/1ps
module acs_filter_model #(
   parameter int PER = 10  // clocks per conversion period
) (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic [1:0]  route,
   input  wire logic [23:0] ext_val,
   output logic             sample_valid,
   output logic [23:0]      sample_data
);
   int cnt_ff;  // free-running period counter, not aligned to the sequencer on purpose
   // word per switch setting; the bench picks ext_val before it selects a mode
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_ff       <= 0;
         sample_valid <= 1'b0;
         sample_data  <= 24'h000000;
      end else if (cnt_ff == PER - 1) begin
         cnt_ff       <= 0;
         sample_valid <= 1'b1;
         case (route)
            2'h1:    sample_data <= 24'h000012;  // shorted inputs
            2'h2:    sample_data <= 24'h7FF000;  // reference, positive
            2'h3:    sample_data <= 24'h001000;  // reference, negative
            default: sample_data <= ext_val;     // external input
         endcase
      end else begin
         cnt_ff       <= cnt_ff + 1;
         sample_valid <= 1'b0;
         // word is stale outside the pulse, so show a changing pattern
         sample_data  <= ~sample_data;
      end
   end
endmodule

// ### sim/acs_sequencer_tb.sv
// self-checking bench for the calibration sequencer
`timescale 1ns/1ps
module acs_sequencer_tb;
   localparam int PER = 10;  // short conversion period keeps the run brief
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] PRDATA;
   logic        PREADY;
   logic        PSLVERR;
   logic        sv;
   logic [23:0] sd;
   logic [1:0]  INPUT_ROUTE;
   logic        RESULT_VALID_N;
   logic [23:0] ext_val = 24'h000000;  // analog input the host has settled
   int err_total = 0;
   int total_checks = 0;
   // 50 MHz clock
   always #10 clk = ~clk;
   acs_sequencer dut (.CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(PRDATA),
      .PREADY(PREADY), .PSLVERR(PSLVERR), .SAMPLE_VALID(sv), .SAMPLE_DATA(sd),
      .INPUT_ROUTE(INPUT_ROUTE), .RESULT_VALID_N(RESULT_VALID_N));
   acs_filter_model #(.PER(PER)) far (.clk(clk), .nrst(nrst), .route(INPUT_ROUTE),
      .ext_val(ext_val), .sample_valid(sv), .sample_data(sd));
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one apb transfer; request held until pready is seen high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic er);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (PREADY !== 1'b1 && n < 50);
      if (PREADY !== 1'b1) begin
         err_total++;
         print_verdict();
      end
      // answer taken at the edge where pready is seen high, then released
      rd = PRDATA;
      er = PSLVERR;
      psel <= 1'b0;
      penable <= 1'b0;
      // one idle edge so a following call never reassigns psel in this step
      @(posedge clk);
   endtask
   // read a register and compare it
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      logic e;
      apb(1'b0, a, 32'h00000000, d, e);
      chk({8'h00, d[23:0]}, exp);
   endtask
   // start a mode, time the data-ready flag, optionally check the switch per step
   task automatic run_mode(input logic [2:0] md, input int n, input logic [7:0] rts);
      int t;
      logic [31:0] d;
      logic e;
      apb(1'b1, acs_pkg::REG_CTRL, {29'h0, md}, d, e);  // package codes only
      t = 0;
      while (RESULT_VALID_N !== 1'b0 && t < 2000) begin
         @(negedge clk);
         t++;
         if (rts != 8'h00 && t % (3 * PER) == 15)
            chk({30'h0, INPUT_ROUTE}, {30'h0, rts[2 * (t / (3 * PER)) +: 2]});
      end
      if (t >= 2000) begin
         err_total++;
         print_verdict();
      end
      chk({31'h0, t >= n * PER - 2 && t <= n * PER + 5}, 32'h1);
      @(posedge clk);
      apb(1'b0, acs_pkg::REG_DATA, 32'h0, d, e);
      @(negedge clk);
      if (md != acs_pkg::MD_CONV)
         chk({31'h0, RESULT_VALID_N}, 32'h1);
      $display("mode %0d done after %0d cycles", md, t);
   endtask
   task automatic t_regs();
      logic [31:0] d;
      logic e;
      rdchk(acs_pkg::REG_OFFSET, 32'h00000000);
      rdchk(acs_pkg::REG_POSFS, 32'h00800000);
      rdchk(acs_pkg::REG_NEGFS, 32'h00800000);
      rdchk(acs_pkg::REG_PERIOD, 32'h00000064);
      apb(1'b0, 8'h1C, 32'h0, d, e);
      chk({e, d[30:0]}, 32'h80000000);
      apb(1'b1, acs_pkg::REG_PERIOD, PER, d, e);
      rdchk(acs_pkg::REG_PERIOD, PER);
      $display("register test done");
   endtask
   task automatic t_self();
      run_mode(acs_pkg::MD_SELF, 12, 8'h39);  // gain field zero, as the host must
      rdchk(acs_pkg::REG_OFFSET, 32'h00000012);
      rdchk(acs_pkg::REG_POSFS, 32'h007FF000);
      rdchk(acs_pkg::REG_NEGFS, 32'h00001000);
      $display("self calibration test done");
   endtask
   task automatic t_system();
      ext_val <= 24'h000040;  // zero point settled first
      run_mode(acs_pkg::MD_SYS_OFF, 4, 8'h00);
      rdchk(acs_pkg::REG_OFFSET, 32'h00000040);
      ext_val <= 24'h700000;  // positive full scale settled, span in range
      run_mode(acs_pkg::MD_SYS_POS, 4, 8'h00);
      rdchk(acs_pkg::REG_POSFS, 32'h00700000);
      ext_val <= 24'h000200;  // negative full scale settled
      run_mode(acs_pkg::MD_SYS_NEG, 4, 8'h00);
      rdchk(acs_pkg::REG_NEGFS, 32'h00000200);
      $display("system calibration test done");
   endtask
   task automatic t_offint_gain();
      ext_val <= 24'h000030;  // zero point settled
      run_mode(acs_pkg::MD_OFF_IGAIN, 12, 8'h38);
      rdchk(acs_pkg::REG_OFFSET, 32'h00000030);
      rdchk(acs_pkg::REG_POSFS, 32'h007FF000);
      rdchk(acs_pkg::REG_NEGFS, 32'h00001000);
      ext_val <= 24'h6F0000;  // positive full scale settled
      run_mode(acs_pkg::MD_SYS_GAIN, 7, 8'h00);
      rdchk(acs_pkg::REG_NEGFS, 32'h006F0000);
      rdchk(acs_pkg::REG_POSFS, 32'h00001000);
      $display("offset and gain calibration test done");
   endtask
   task automatic t_conv();
      ext_val <= 24'h123456;
      run_mode(acs_pkg::MD_CONV, 3, 8'h00);
      rdchk(acs_pkg::REG_DATA, 32'h00123426);
      rdchk(acs_pkg::REG_OFFSET, 32'h00000030);
      rdchk(acs_pkg::REG_NEGFS, 32'h006F0000);
      $display("conversion test done");
   endtask
   initial begin
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      t_regs();
      t_self();
      t_system();
      t_offint_gain();
      t_conv();
      print_verdict();
   end
endmodule
